// [dv/sbce_host.sv]
// Transmit sink of the programming controller; takes bytes every cycle, at random pace or not at all.
module sbce_host (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic stall,
  input  wire logic fast,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_q;
  always_ff @(negedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_q <= 8'h5A;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end
  assign tx_ready = !stall && (fast || lfsr_q[0]);
endmodule

// [dv/test_serial_boot_command_engine.sv]
module test_serial_boot_command_engine;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [95:0] PID = 96'h5445_5354_4944_2020_2020_2020; // Arbitrary value.
  logic ref_clk, rst_b, rx_valid, baud_ok, rd_open, wr_open, tx_ready, stall, fast;
  logic tx_valid, jump_valid, handoff_valid, jump_ok;
  logic [31:0] sw_id, jump_addr, ja_exp;
  logic [15:0] flash_sum;
  logic [7:0]  tx_data, handoff_cmd, run_sum, ho_exp;
  logic [9:0]  e;
  logic [9:0]  exq[$];
  logic [39:0] wq[$];
  sbce_pkg::sbce_rx_t     rx_byte;
  sbce_pkg::sbce_ram_wr_t ram_wr;
  int err_total, total_checks, seed, jumps, hands;

  sbce_engine #(.PART_ID(PID), .FIFO_DEPTH(8)) sbce_engine_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .baud_ok(baud_ok), .sw_id(sw_id), .rd_open(rd_open), .wr_open(wr_open),
    .flash_sum(flash_sum), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .ram_wr(ram_wr), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .handoff_valid(handoff_valid), .handoff_cmd(handoff_cmd));
  sbce_host sbce_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .fast(fast),
    .tx_ready(tx_ready));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Kind 0 exact, 1 any value, 2 exact and restart the sum, 3 sum must come to zero.
  task automatic ex(input logic [1:0] k, input logic [7:0] b);
    exq.push_back({k, b});
  endtask

  task automatic ex32(input logic [31:0] w);
    for (int i = 0; i < 4; i++) ex(2'd0, w[8*i+:8]);
  endtask

  task automatic send(input logic er, input logic [7:0] b);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_byte = {er, b};
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exq.size() != 0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check("answer count", 40'(exq.size()), 40'h0);
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic ram(input int mode);
    logic [47:0] hb;
    logic [7:0]  s, d;
    logic [15:0] n;
    n = (mode == 3) ? 16'h0000 : 16'h0003;
    hb = {32'h00001000 + 32'($random(seed) & 32'hFF), n};
    s = 8'h00;
    ex(2'd2, 8'h10);
    send(1'b0, 8'h10);
    drain;
    for (int i = 0; i < 6; i++) begin
      d = hb[47-8*i-:8];
      s = s + d;
      send(mode == 0 && i == 2, d);
    end
    send(1'b0, (mode == 1) ? 8'(1 - s) : 8'(-s));
    if (mode < 2) begin
      ex(2'd0, (mode == 0) ? 8'h18 : 8'h11);
    end else begin
      s = 8'h00;
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        s = s + d;
        wq.push_back({hb[47:16] + 32'(i), d});
        send(1'b0, d);
      end
      jump_ok = (mode == 4);
      ja_exp = hb[47:16];
      ex(2'd0, (mode == 2) ? 8'h11 : (mode == 3) ? 8'h18 : 8'h10);
      send(mode == 3, (mode == 2) ? 8'(1 - s) : 8'(-s));
    end
    drain;
  endtask

  always @(posedge ref_clk) begin
    if (rst_b && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exq.size() == 0) begin
        check("unexpected byte", 40'h1, 40'h0);
      end else begin
        e = exq.pop_front();
        if (e[9:8] == 2'd3) check("stream checksum", 40'(8'(run_sum + tx_data)), 40'h0);
        else if (e[9:8] != 2'd1) check("tx byte", 40'(tx_data), 40'(e[7:0]));
        run_sum = (e[9:8] == 2'd2) ? 8'h00 : 8'(run_sum + tx_data);
      end
    end
    if (ram_wr.we === 1'b1) begin
      if (wq.size() == 0) check("unexpected write", 40'h1, 40'h0);
      else check("ram write", {ram_wr.addr, ram_wr.data}, wq.pop_front());
    end
    if (handoff_valid === 1'b1) begin
      hands++;
      check("handoff", 40'(handoff_cmd), 40'(ho_exp));
    end
    if (jump_valid === 1'b1) begin
      jumps++;
      check("jump allowed", 40'(jump_ok), 40'h1);
      check("jump address", 40'(jump_addr), 40'(ja_exp));
    end
  end

  initial begin
    #1000000;
    err_total++;
    end_sim();
  end

  initial begin
    seed = 29;
    {rst_b, rx_valid, stall, jump_ok, run_sum, ho_exp, ja_exp, jumps} = '0;
    {err_total, total_checks} = '0;
    hands = 0;
    rx_byte = '0;
    {baud_ok, fast} = 2'b11;
    {rd_open, wr_open} = 2'($random(seed));
    sw_id = 32'($random(seed));
    flash_sum = 16'($random(seed));
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    ex(2'd0, 8'h86);
    send(1'b0, 8'h86);
    drain;
    ex(2'd0, 8'h08);
    send(1'b1, 8'h20);
    drain;
    ex(2'd0, 8'h01);
    send(1'b0, 8'h55);
    drain;
    ex(2'd2, 8'h20);
    ex(2'd0, flash_sum[15:8]);
    ex(2'd0, flash_sum[7:0]);
    ex(2'd0, 8'(-(flash_sum[15:8] + flash_sum[7:0])));
    send(1'b0, 8'h20);
    drain;
    ex(2'd0, 8'h28);
    send(1'b1, 8'h33);
    drain;
    ex(2'd0, 8'h21);
    send(1'b0, 8'hA5);
    drain;
    ex(2'd2, 8'h30);
    ex32(sw_id);
    for (int i = 0; i < 12; i++) ex(2'd0, PID[95-8*i-:8]);
    ex32(32'h0002FEF4);
    ex32(32'h00001000);
    ex32(32'h00003DFF);
    ex32(32'h00003FFF);
    for (int i = 0; i < 8; i++) ex(2'd1, 8'h00);
    ex(2'd0, {5'h00, 1'b0, wr_open, rd_open});
    ex(2'd0, 8'h00);
    ex32(32'h00010000);
    ex32(32'h0002FFFF);
    ex(2'd0, 8'h20);
    ex(2'd0, 8'h00);
    ex32(32'h00010000);
    ex32(32'h00000800);
    ex(2'd0, 8'h20);
    ex(2'd3, 8'h00);
    stall = 1'b1;
    send(1'b0, 8'h30);
    repeat (60) @(negedge ref_clk);
    check("fifo holds", {39'h0, tx_valid}, 40'h1);
    check("nothing taken", 40'(exq.size()), 40'd63);
    stall = 1'b0;
    fast = 1'b0;
    drain;
    for (int i = 0; i < 2; i++) begin
      ho_exp = (i == 0) ? 8'h40 : 8'h60;
      ex(2'd2, ho_exp);
      send(1'b0, ho_exp);
      drain;
    end
    check("handoff count", 40'(hands), 40'h2);
    for (int m = 0; m < 5; m++) ram(m);
    check("jump count", 40'(jumps), 40'h1);
    check("writes left", 40'(wq.size()), 40'h0);
    rst_b = 1'b0;
    baud_ok = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    send(1'b0, 8'h86);
    send(1'b0, 8'h20);
    repeat (50) @(negedge ref_clk);
    check("silent after bad rate", {39'h0, tx_valid}, 40'h0);
    end_sim();
  end
endmodule

// [verilog/sbce_defines.svh]
`ifndef SBCE_DEFINES_SVH
`define SBCE_DEFINES_SVH

// Session opening byte and command bytes.
`define SBCE_BAUD_BYTE    8'h86
`define SBCE_CMD_RAM      8'h10
`define SBCE_CMD_SUM      8'h20
`define SBCE_CMD_INFO     8'h30
`define SBCE_CMD_ERASE    8'h40
`define SBCE_CMD_PROT     8'h60

// Acknowledge low nibbles and the fixed payload acknowledges.
`define SBCE_ACK_RXERR    4'h8
`define SBCE_ACK_BAD      4'h1
`define SBCE_ACK_OK       8'h10
`define SBCE_ACK_RAM_ERR  8'h18
`define SBCE_ACK_RAM_SUM  8'h11

// Last index of each phase; index 0 of a stream is the echoed command.
`define SBCE_HDR_LAST     6'h06
`define SBCE_SUM_LAST     6'h03
`define SBCE_INFO_LAST    6'h3E

// Product information fields.
`define SBCE_PW_ADDR      32'h0002FEF4
`define SBCE_RAM_START    32'h00001000
`define SBCE_URAM_END     32'h00003DFF
`define SBCE_RAM_END      32'h00003FFF
`define SBCE_FLASH_START  32'h00010000
`define SBCE_FLASH_END    32'h0002FFFF
`define SBCE_SECT_COUNT   16'h0020
`define SBCE_SECT_WORDS   32'h00000800
`define SBCE_SECT_RUN     8'h20

// Status word bit positions.
`define SBCE_ST_RD_OPEN   0
`define SBCE_ST_WR_OPEN   1
`define SBCE_ST_UNSECT    2

`endif

// [verilog/sbce_engine.sv]
`include "sbce_defines.svh"

// Shift-register FIFO: the head always sits in word 0, so the read side is a flop.
module sbce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic [CW-1:0]    wr_idx;
  logic             vld_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = vld_q;
  assign out_data  = mem_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = vld_q && out_ready;
  assign cnt_d     = cnt_q + CW'(push) - CW'(pop);
  assign wr_idx    = cnt_q - CW'(pop);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      vld_q <= (cnt_d != '0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && wr_idx == CW'(i)) begin
          mem_q[i] <= in_data;
        end else if (pop && i < DEPTH - 1) begin
          mem_q[i] <= mem_q[i+1];
        end
      end
    end
  end
endmodule

module sbce_engine #(
  parameter logic [95:0] PART_ID = 96'h424F_4F54_5041_5254_2020_2020, // Arbitrary value.
  parameter int          FIFO_DEPTH = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  rx_valid,
  input  wire sbce_pkg::sbce_rx_t    rx_byte,
  input  wire logic                  baud_ok,
  input  wire logic [31:0]           sw_id,
  input  wire logic                  rd_open,
  input  wire logic                  wr_open,
  input  wire logic [15:0]           flash_sum,
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  input  wire logic                  tx_ready,
  output sbce_pkg::sbce_ram_wr_t     ram_wr,
  output logic                       jump_valid,
  output logic [31:0]                jump_addr,
  output logic                       handoff_valid,
  output logic [7:0]                 handoff_cmd
);
  sbce_pkg::sbce_state_t  state_q;
  sbce_pkg::sbce_state_t  ret_q;
  sbce_pkg::sbce_mode_t   mode_q;
  sbce_pkg::sbce_ram_wr_t ram_q;
  logic [5:0]             idx_q;
  logic [7:0]             ack_q;
  logic [7:0]             acc_q;
  logic                   rxerr_q;
  logic [47:0]            hdr_q;
  logic [15:0]            off_q;
  logic [15:0]            sum_q;
  logic [3:0]             last_hi_q;
  logic                   jump_q;
  logic                   hand_q;
  logic [7:0]             hcmd_q;
  logic                   push;
  logic                   fifo_ready;
  logic                   send_last;
  logic [7:0]             emit;
  logic [7:0]             rx_sum;
  logic                   rx_bad;

  function automatic logic [7:0] le_byte(input logic [31:0] w, input logic [1:0] k);
    le_byte = w[8*k +: 8];
  endfunction

  // Product information data byte n, counted from the first data byte.
  function automatic logic [7:0] info_byte(input logic [5:0] n, input logic [31:0] id,
                                           input logic [15:0] st, input logic [95:0] part);
    logic [1:0] k;
    k = n[1:0];
    info_byte = 8'h00;
    if (n < 6'd4) begin
      info_byte = le_byte(id, k);
    end else if (n < 6'd16) begin
      info_byte = part[8*(6'd15 - n) +: 8];
    end else if (n < 6'd20) begin
      info_byte = le_byte(`SBCE_PW_ADDR, k);
    end else if (n < 6'd24) begin
      info_byte = le_byte(`SBCE_RAM_START, k);
    end else if (n < 6'd28) begin
      info_byte = le_byte(`SBCE_URAM_END, k);
    end else if (n < 6'd32) begin
      info_byte = le_byte(`SBCE_RAM_END, k);
    end else if (n < 6'd40) begin
      info_byte = 8'h00;
    end else if (n < 6'd42) begin
      info_byte = n[0] ? st[15:8] : st[7:0];
    end else if (n < 6'd46) begin
      info_byte = le_byte(`SBCE_FLASH_START, 2'(n - 6'd42));
    end else if (n < 6'd50) begin
      info_byte = le_byte(`SBCE_FLASH_END, 2'(n - 6'd46));
    end else if (n < 6'd52) begin
      info_byte = n[0] ? 8'(`SBCE_SECT_COUNT >> 8) : 8'(`SBCE_SECT_COUNT);
    end else if (n < 6'd56) begin
      info_byte = le_byte(`SBCE_FLASH_START, 2'(n - 6'd52));
    end else if (n < 6'd60) begin
      info_byte = le_byte(`SBCE_SECT_WORDS, 2'(n - 6'd56));
    end else begin
      info_byte = `SBCE_SECT_RUN;
    end
  endfunction

  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[`SBCE_ST_RD_OPEN] = rd_open;
    status_word[`SBCE_ST_WR_OPEN] = wr_open;
    status_word[`SBCE_ST_UNSECT]  = 1'b0;
  end

  assign rx_sum = acc_q + rx_byte.data;
  assign rx_bad = rxerr_q || rx_byte.err;
  assign push   = (state_q == sbce_pkg::SBCE_ST_SEND) && fifo_ready;

  always_comb begin
    send_last = 1'b0;
    emit      = ack_q;
    case (mode_q)
      sbce_pkg::SBCE_MD_SUM: begin
        send_last = (idx_q == `SBCE_SUM_LAST);
        if (idx_q == 6'd1) begin
          emit = sum_q[15:8];
        end else if (idx_q == 6'd2) begin
          emit = sum_q[7:0];
        end else if (send_last) begin
          emit = 8'h00 - acc_q;
        end
      end
      sbce_pkg::SBCE_MD_INFO: begin
        send_last = (idx_q == `SBCE_INFO_LAST);
        if (send_last) begin
          emit = 8'h00 - acc_q;
        end else if (idx_q != 6'd0) begin
          emit = info_byte(idx_q - 6'd1, sw_id, status_word, PART_ID);
        end
      end
      default: begin
        send_last = 1'b1;
      end
    endcase
  end

  // Main sequence: command decode, header, payload and response streaming.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= sbce_pkg::SBCE_ST_BAUD;
      ret_q   <= sbce_pkg::SBCE_ST_CMD;
      mode_q  <= sbce_pkg::SBCE_MD_ACK;
      idx_q   <= 6'h00;
      ack_q   <= 8'h00;
    end else begin
      case (state_q)
        sbce_pkg::SBCE_ST_BAUD: begin
          if (rx_valid) begin
            if (!rx_byte.err && rx_byte.data == `SBCE_BAUD_BYTE && baud_ok) begin
              ack_q   <= `SBCE_BAUD_BYTE;
              mode_q  <= sbce_pkg::SBCE_MD_ACK;
              ret_q   <= sbce_pkg::SBCE_ST_CMD;
              state_q <= sbce_pkg::SBCE_ST_SEND;
            end else begin
              state_q <= sbce_pkg::SBCE_ST_HALT;
            end
          end
        end
        sbce_pkg::SBCE_ST_CMD: begin
          if (rx_valid) begin
            mode_q  <= sbce_pkg::SBCE_MD_ACK;
            ret_q   <= sbce_pkg::SBCE_ST_CMD;
            state_q <= sbce_pkg::SBCE_ST_SEND;
            idx_q   <= 6'h00;
            ack_q   <= rx_byte.data;
            if (rx_byte.err) begin
              ack_q <= {last_hi_q, `SBCE_ACK_RXERR};
            end else begin
              case (rx_byte.data)
                `SBCE_CMD_RAM: ret_q <= sbce_pkg::SBCE_ST_HDR;
                `SBCE_CMD_SUM: mode_q <= sbce_pkg::SBCE_MD_SUM;
                `SBCE_CMD_INFO: mode_q <= sbce_pkg::SBCE_MD_INFO;
                `SBCE_CMD_ERASE, `SBCE_CMD_PROT: ret_q <= sbce_pkg::SBCE_ST_CMD;
                default: ack_q <= {last_hi_q, `SBCE_ACK_BAD};
              endcase
            end
          end
        end
        sbce_pkg::SBCE_ST_HDR: begin
          if (rx_valid) begin
            idx_q <= idx_q + 6'd1;
            if (idx_q == `SBCE_HDR_LAST) begin
              idx_q <= 6'h00;
              if (rx_bad || rx_sum != 8'h00) begin
                ack_q   <= rx_bad ? `SBCE_ACK_RAM_ERR : `SBCE_ACK_RAM_SUM;
                mode_q  <= sbce_pkg::SBCE_MD_ACK;
                ret_q   <= sbce_pkg::SBCE_ST_CMD;
                state_q <= sbce_pkg::SBCE_ST_SEND;
              end else if (hdr_q[15:0] == 16'h0000) begin
                state_q <= sbce_pkg::SBCE_ST_PCK;
              end else begin
                state_q <= sbce_pkg::SBCE_ST_DATA;
              end
            end
          end
        end
        sbce_pkg::SBCE_ST_DATA: begin
          if (rx_valid && off_q == hdr_q[15:0] - 16'd1) begin
            state_q <= sbce_pkg::SBCE_ST_PCK;
          end
        end
        sbce_pkg::SBCE_ST_PCK: begin
          if (rx_valid) begin
            mode_q  <= sbce_pkg::SBCE_MD_ACK;
            state_q <= sbce_pkg::SBCE_ST_SEND;
            ret_q   <= sbce_pkg::SBCE_ST_CMD;
            if (rx_bad) begin
              ack_q <= `SBCE_ACK_RAM_ERR;
            end else if (rx_sum != 8'h00) begin
              ack_q <= `SBCE_ACK_RAM_SUM;
            end else begin
              ack_q <= `SBCE_ACK_OK;
              ret_q <= sbce_pkg::SBCE_ST_RUN;
            end
          end
        end
        sbce_pkg::SBCE_ST_SEND: begin
          if (push) begin
            idx_q <= idx_q + 6'd1;
            if (send_last) begin
              idx_q   <= 6'h00;
              state_q <= ret_q;
            end
          end
        end
        sbce_pkg::SBCE_ST_RUN: state_q <= sbce_pkg::SBCE_ST_HALT;
        sbce_pkg::SBCE_ST_HALT: state_q <= sbce_pkg::SBCE_ST_HALT;
        default: state_q <= sbce_pkg::SBCE_ST_BAUD;
      endcase
    end
  end

  // Running byte sum and sticky receive error of the current phase.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q   <= 8'h00;
      rxerr_q <= 1'b0;
    end else if (state_q == sbce_pkg::SBCE_ST_CMD) begin
      acc_q   <= 8'h00;
      rxerr_q <= 1'b0;
    end else if (state_q == sbce_pkg::SBCE_ST_HDR && rx_valid) begin
      acc_q   <= (idx_q == `SBCE_HDR_LAST) ? 8'h00 : rx_sum;
      rxerr_q <= (idx_q == `SBCE_HDR_LAST) ? 1'b0 : rx_bad;
    end else if (state_q == sbce_pkg::SBCE_ST_DATA && rx_valid) begin
      acc_q   <= rx_sum;
      rxerr_q <= rx_bad;
    end else if (push && idx_q != 6'd0 && !send_last) begin
      acc_q <= acc_q + emit;
    end
  end

  // Header fields, flash sum snapshot and the command nibble kept for acknowledges.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_q     <= 48'h0;
      sum_q     <= 16'h0000;
      last_hi_q <= 4'h0;
      hand_q    <= 1'b0;
      hcmd_q    <= 8'h00;
    end else begin
      hand_q <= 1'b0;
      if (state_q == sbce_pkg::SBCE_ST_HDR && rx_valid && idx_q != `SBCE_HDR_LAST) begin
        hdr_q <= {hdr_q[39:0], rx_byte.data};
      end
      if (state_q == sbce_pkg::SBCE_ST_CMD && rx_valid && !rx_byte.err) begin
        case (rx_byte.data)
          `SBCE_CMD_RAM, `SBCE_CMD_SUM, `SBCE_CMD_INFO, `SBCE_CMD_ERASE, `SBCE_CMD_PROT: begin
            last_hi_q <= rx_byte.data[7:4];
            sum_q     <= flash_sum;
            hand_q    <= (rx_byte.data == `SBCE_CMD_ERASE) || (rx_byte.data == `SBCE_CMD_PROT);
            hcmd_q    <= rx_byte.data;
          end
          default: hand_q <= 1'b0;
        endcase
      end
    end
  end

  // RAM write port and jump request.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_q     <= '0;
      off_q     <= 16'h0000;
      jump_q    <= 1'b0;
      jump_addr <= 32'h0;
    end else begin
      ram_q.we <= 1'b0;
      jump_q   <= (state_q == sbce_pkg::SBCE_ST_RUN);
      if (state_q == sbce_pkg::SBCE_ST_HDR) begin
        off_q <= 16'h0000;
      end
      if (state_q == sbce_pkg::SBCE_ST_DATA && rx_valid) begin
        ram_q.we   <= 1'b1;
        ram_q.addr <= hdr_q[47:16] + {16'h0000, off_q};
        ram_q.data <= rx_byte.data;
        off_q      <= off_q + 16'd1;
      end
      if (state_q == sbce_pkg::SBCE_ST_RUN) begin
        jump_addr <= hdr_q[47:16];
      end
    end
  end

  assign ram_wr        = ram_q;
  assign jump_valid    = jump_q;
  assign handoff_valid = hand_q;
  assign handoff_cmd   = hcmd_q;

  sbce_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (state_q == sbce_pkg::SBCE_ST_SEND),
    .in_data   (emit),
    .in_ready  (fifo_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_hdr_err;
    state_q == sbce_pkg::SBCE_ST_HDR && rx_valid && idx_q == `SBCE_HDR_LAST && rx_bad
      |=> state_q == sbce_pkg::SBCE_ST_SEND && ack_q == 8'h18 && ret_q == sbce_pkg::SBCE_ST_CMD;
  endproperty
  a_hdr_err: assert property (p_hdr_err) else $error("header error ack wrong");

  property p_hdr_sum;
    state_q == sbce_pkg::SBCE_ST_HDR && rx_valid && idx_q == `SBCE_HDR_LAST && !rx_bad
      && rx_sum != 8'h00 |=> ack_q == 8'h11 && state_q == sbce_pkg::SBCE_ST_SEND;
  endproperty
  a_hdr_sum: assert property (p_hdr_sum) else $error("header sum ack wrong");

  property p_ram_wr;
    state_q == sbce_pkg::SBCE_ST_DATA && rx_valid
      |=> ram_wr.we && ram_wr.data == $past(rx_byte.data)
          && ram_wr.addr == hdr_q[47:16] + {16'h0000, off_q} - 32'd1;
  endproperty
  a_ram_wr: assert property (p_ram_wr) else $error("payload write wrong");

  property p_pay_ack;
    state_q == sbce_pkg::SBCE_ST_PCK && rx_valid
      |=> ack_q == ($past(rx_bad) ? 8'h18 : ($past(rx_sum) != 8'h00 ? 8'h11 : 8'h10));
  endproperty
  a_pay_ack: assert property (p_pay_ack) else $error("payload ack wrong");

  property p_jump;
    $rose(jump_valid) |-> $past(state_q, 2) == sbce_pkg::SBCE_ST_SEND && $past(ack_q, 2) == 8'h10;
  endproperty
  a_jump: assert property (p_jump) else $error("jump without good ack");

  property p_cmd_err;
    state_q == sbce_pkg::SBCE_ST_CMD && rx_valid && rx_byte.err
      |=> ack_q == {$past(last_hi_q), 4'h8} ##1 tx_valid[*1];
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("command error ack wrong");

  property p_cmd_bad;
    state_q == sbce_pkg::SBCE_ST_CMD && rx_valid && !rx_byte.err
      && !(rx_byte.data inside {`SBCE_CMD_RAM, `SBCE_CMD_SUM, `SBCE_CMD_INFO,
                                `SBCE_CMD_ERASE, `SBCE_CMD_PROT})
      |=> ack_q == {$past(last_hi_q), `SBCE_ACK_BAD} && last_hi_q == $past(last_hi_q);
  endproperty
  a_cmd_bad: assert property (p_cmd_bad) else $error("unknown command ack wrong");

  property p_sum_seq;
    state_q == sbce_pkg::SBCE_ST_CMD && rx_valid && !rx_byte.err && rx_byte.data == 8'h20
      ##1 push [*2] |-> emit == sum_q[15:8] || !fifo_ready;
  endproperty
  a_sum_seq: assert property (p_sum_seq) else $error("sum upper byte not first");

  property p_echo;
    state_q == sbce_pkg::SBCE_ST_CMD && rx_valid && !rx_byte.err
      && (rx_byte.data == 8'h20 || rx_byte.data == 8'h30) |=> emit == $past(rx_byte.data);
  endproperty
  a_echo: assert property (p_echo) else $error("command not echoed");

  property p_send_bound;
    state_q == sbce_pkg::SBCE_ST_SEND && mode_q == sbce_pkg::SBCE_MD_ACK && fifo_ready
      |=> state_q != sbce_pkg::SBCE_ST_SEND || ret_q == sbce_pkg::SBCE_ST_SEND;
  endproperty
  a_send_bound: assert property (p_send_bound) else $error("ack not sent in one cycle");

  c_download: cover property (state_q == sbce_pkg::SBCE_ST_RUN);
  c_sum_done: cover property (push && mode_q == sbce_pkg::SBCE_MD_SUM && send_last);
  c_info_done: cover property (push && mode_q == sbce_pkg::SBCE_MD_INFO && send_last);
  c_fifo_full: cover property (state_q == sbce_pkg::SBCE_ST_SEND && !fifo_ready);
endmodule

// [verilog/sbce_pkg.sv]
package sbce_pkg;

  typedef enum logic [3:0] {
    SBCE_ST_BAUD = 4'b0000,
    SBCE_ST_CMD  = 4'b0001,
    SBCE_ST_HDR  = 4'b0010,
    SBCE_ST_DATA = 4'b0011,
    SBCE_ST_PCK  = 4'b0100,
    SBCE_ST_SEND = 4'b0101,
    SBCE_ST_RUN  = 4'b0110,
    SBCE_ST_HALT = 4'b0111
  } sbce_state_t;

  typedef enum logic [1:0] {
    SBCE_MD_ACK  = 2'b00,
    SBCE_MD_SUM  = 2'b01,
    SBCE_MD_INFO = 2'b10
  } sbce_mode_t;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } sbce_rx_t;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [7:0]  data;
  } sbce_ram_wr_t;

endpackage
